// [vcd_data_ports.sv]
/*
 digital data ports of a video codec: input select decode, digitizer output
 bus with chroma marker, three-mode DAC bus capture, overlay switch, APB registers.
 assumes the video and overlay pins are asynchronous to clk_sys and change no faster than one
 level per two clk_sys cycles; the SAR result arrives on clk_sys.
*/
// Design decisions made here: the APB register port and the register addresses.
`default_nettype none
module vcd_data_ports #(
	parameter int DATA_W = vcd_pkg::DATA_W,
	parameter int CORE_W = vcd_pkg::CORE_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              crystal_clock_in,
	input  wire logic [CORE_W-1:0] adc_core_sample,
	output logic      [DATA_W-1:0] adc_data_out,
	output logic                   chroma_phase_marker,
	output logic      [2:0]        luma_source,
	output logic      [2:0]        chroma_source,
	output logic      [2:0]        v_source,
	output logic                   aux_enable,
	output logic      [5:0]        single_ended,
	output logic                   leg_to_reference,
	output logic      [2:0]        aux_channel_sel,
	input  wire logic [7:0]        aux_sar_result,
	input  wire logic              aux_sar_done,
	input  wire logic              dac_clock_a,
	input  wire logic              dac_clock_b,
	input  wire logic [DATA_W-1:0] dac_input_bus,
	output logic      [DATA_W-1:0] dac0_data,
	output logic      [DATA_W-1:0] dac1_data,
	output logic      [DATA_W-1:0] dac2_data,
	output logic      [DATA_W-1:0] dac3_data,
	output logic      [3:0]        dac_update,
	input  wire logic [2:0]        overlay_inputs,
	input  wire logic              overlay_switch_enable,
	output logic      [2:0]        overlay_out,
	output logic                   overlay_active
);
	// ==========================================================
	// pin synchroniser layout
	localparam int PIN_W  = 4 + 3 + DATA_W + CORE_W;
	localparam int P_XTAL = 0;
	localparam int P_CKA  = 1;
	localparam int P_CKB  = 2;
	localparam int P_OSDE = 3;
	localparam int P_OSD  = 4;
	localparam int P_DBUS = 7;
	localparam int P_CORE = 7 + DATA_W;

	typedef struct packed {
		logic [PIN_W-1:0]  s1;
		logic [PIN_W-1:0]  s2;
		logic [PIN_W-1:0]  s3;
		logic [PIN_W-1:0]  filt;
		logic [3:0]        sel;
		logic [1:0]        mode;
		logic [2:0]        auxch;
		logic [7:0]        auxres;
		logic              aux_fresh;
		logic [1:0]        phase;
		logic [DATA_W-1:0] adc_out;
		logic              marker;
		logic [1:0]        steer;
		logic              seen_mark;
		logic              chroma_turn;
		logic [DATA_W-1:0] dac0;
		logic [DATA_W-1:0] dac1;
		logic [DATA_W-1:0] dac2;
		logic [DATA_W-1:0] dac3;
		logic [3:0]        upd;
		logic [2:0]        osd;
		logic              osd_on;
		logic [31:0]       rdata;
		logic              ready;
		logic              slverr;
	} vcd_state_t;

	vcd_state_t st;
	vcd_state_t next_st;
	// ==========================================================
	// helpers
	function automatic logic [PIN_W-1:0] vcd_settle(input logic [PIN_W-1:0] a, input logic [PIN_W-1:0] b,
		input logic [PIN_W-1:0] old);
		vcd_settle = (a & b) | (old & (a | b));
	endfunction
	function automatic logic vcd_mapped(input logic [7:0] addr);
		vcd_mapped = (addr == vcd_pkg::REG_INPUT_SELECT) || (addr == vcd_pkg::REG_DAC_MODE) ||
			(addr == vcd_pkg::REG_AUX_CHANNEL) || (addr == vcd_pkg::REG_AUX_RESULT) ||
			(addr == vcd_pkg::REG_STATUS);
	endfunction
	function automatic logic vcd_is_aux(input logic [3:0] sel);
		vcd_is_aux = (sel == vcd_pkg::SEL_AUX_1) || (sel == vcd_pkg::SEL_AUX_2);
	endfunction
	// filtered pin view and edges
	logic [PIN_W-1:0] settled;
	logic             xtal_rise;
	logic             a_rise;
	logic             a_fall;
	logic             b_rise;
	logic             b_fall;
	logic             apb_setup;
	logic             apb_done;
	logic [3:0]       wr_sel;
	logic [1:0]       wr_mode;

	assign settled   = vcd_settle(st.s2, st.s3, st.filt);
	assign xtal_rise = settled[P_XTAL] & ~st.filt[P_XTAL];
	assign a_rise    = settled[P_CKA] & ~st.filt[P_CKA];
	assign a_fall    = ~settled[P_CKA] & st.filt[P_CKA];
	assign b_rise    = settled[P_CKB] & ~st.filt[P_CKB];
	assign b_fall    = ~settled[P_CKB] & st.filt[P_CKB];
	assign apb_setup = psel & ~penable;
	assign apb_done  = psel & penable & st.ready;
	assign wr_sel    = pwdata[vcd_pkg::SEL_W-1:0];
	assign wr_mode   = pwdata[vcd_pkg::MODE_W-1:0];

	// ==========================================================
	// next state
	always_comb begin
		logic [DATA_W-1:0] word;
		logic              yc;
		logic              yuv;
		word    = settled[P_DBUS +: DATA_W];
		yc      = (st.sel == vcd_pkg::SEL_YC_1_4) || (st.sel == vcd_pkg::SEL_YC_2_3);
		yuv     = (st.sel == vcd_pkg::SEL_YUV);
		next_st = st;
		next_st.s1   = {adc_core_sample, dac_input_bus, overlay_inputs, overlay_switch_enable,
			dac_clock_b, dac_clock_a, crystal_clock_in};
		next_st.s2   = st.s1;
		next_st.s3   = st.s2;
		next_st.filt = settled;
		next_st.upd  = 4'h0;

		// digitizer output, one word per crystal rising edge
		if (xtal_rise) begin
			next_st.adc_out = settled[P_CORE + vcd_pkg::HEAD_W +: DATA_W];
			next_st.phase   = st.phase + 2'h1;
			next_st.marker  = (yc && st.phase[0]) || (yuv && st.phase == 2'h2);
			if (!yc && !yuv) begin
				next_st.marker = 1'b0;
			end
		end

		// auxiliary result capture
		if (aux_sar_done && vcd_is_aux(st.sel)) begin
			next_st.auxres    = aux_sar_result;
			next_st.aux_fresh = 1'b1;
		end

		// dac bus capture
		unique case (st.mode)
			vcd_pkg::MODE_SINGLE: begin
				if (b_rise) begin
					logic [1:0] idx;
					idx = settled[P_CKA] ? 2'h0 : (st.seen_mark ? st.steer + 2'h1 : 2'h0);
					next_st.seen_mark = st.seen_mark | settled[P_CKA];
					next_st.steer     = idx;
					next_st.upd[idx]  = 1'b1;
					unique case (idx)
						2'h0: next_st.dac0 = word;
						2'h1: next_st.dac1 = word;
						2'h2: next_st.dac2 = word;
						2'h3: next_st.dac3 = word;
					endcase
				end
			end
			vcd_pkg::MODE_DUAL: begin
				if (a_rise) begin
					next_st.dac0   = word;
					next_st.upd[0] = 1'b1;
				end
				if (b_rise) begin
					next_st.dac1   = word;
					next_st.upd[1] = 1'b1;
				end
				if (a_fall) begin
					next_st.dac2   = word;
					next_st.upd[2] = 1'b1;
				end
				if (b_fall) begin
					next_st.dac3   = word;
					next_st.upd[3] = 1'b1;
				end
			end
			vcd_pkg::MODE_422: begin
				if (b_rise) begin
					if (settled[P_CKA]) begin
						next_st.dac2        = word;
						next_st.upd[2]      = 1'b1;
						next_st.chroma_turn = 1'b0;
					end else if (st.chroma_turn) begin
						next_st.dac0        = word;
						next_st.upd[0]      = 1'b1;
						next_st.chroma_turn = 1'b0;
					end else begin
						next_st.dac1        = word;
						next_st.upd[1]      = 1'b1;
						next_st.chroma_turn = 1'b1;
					end
				end
			end
			vcd_pkg::MODE_OFF: begin
			end
		endcase

		// overlay switch
		next_st.osd_on = settled[P_OSDE];
		next_st.osd    = settled[P_OSDE] ? settled[P_OSD +: 3] : 3'h0;

		// apb slave, answers one cycle after setup
		next_st.ready  = apb_setup;
		next_st.slverr = apb_setup & ~vcd_mapped(paddr);
		if (apb_setup) begin
			next_st.rdata = 32'h0;
			unique case (paddr)
				vcd_pkg::REG_INPUT_SELECT: next_st.rdata[3:0] = st.sel;
				vcd_pkg::REG_DAC_MODE:     next_st.rdata[1:0] = st.mode;
				vcd_pkg::REG_AUX_CHANNEL:  next_st.rdata[2:0] = st.auxch;
				vcd_pkg::REG_AUX_RESULT:   next_st.rdata[7:0] = st.auxres;
				vcd_pkg::REG_STATUS:       next_st.rdata[3:0] = {st.aux_fresh, st.seen_mark, st.steer};
				default:                   next_st.rdata      = 32'h0;
			endcase
		end
		if (apb_done && !pwrite && paddr == vcd_pkg::REG_AUX_RESULT && !(aux_sar_done && vcd_is_aux(st.sel))) begin
			next_st.aux_fresh = 1'b0;
		end
		if (apb_done && pwrite) begin
			unique case (paddr)
				vcd_pkg::REG_INPUT_SELECT: begin
					next_st.sel   = wr_sel;
					next_st.phase = 2'h0;
				end
				vcd_pkg::REG_DAC_MODE: begin
					next_st.mode        = wr_mode;
					next_st.steer       = 2'h0;
					next_st.seen_mark   = 1'b0;
					next_st.chroma_turn = 1'b1;
				end
				vcd_pkg::REG_AUX_CHANNEL: next_st.auxch = pwdata[2:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st             <= '0;
			st.sel         <= vcd_pkg::SEL_RESET;
			st.mode        <= vcd_pkg::MODE_RESET;
			st.auxch       <= vcd_pkg::AUXCH_RESET;
			st.chroma_turn <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// input select decode, registered
	logic [2:0] luma_q;
	logic [2:0] chroma_q;
	logic [2:0] v_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			luma_q   <= 3'h0;
			chroma_q <= 3'h0;
			v_q      <= 3'h0;
		end else begin
			chroma_q <= 3'h0;
			v_q      <= 3'h0;
			unique case (st.sel)
				vcd_pkg::SEL_CVBS_1, vcd_pkg::SEL_AUX_1: luma_q <= 3'h1;
				vcd_pkg::SEL_CVBS_2, vcd_pkg::SEL_AUX_2: luma_q <= 3'h2;
				vcd_pkg::SEL_CVBS_3:                     luma_q <= 3'h3;
				vcd_pkg::SEL_CVBS_5:                     luma_q <= 3'h5;
				vcd_pkg::SEL_CVBS_6:                     luma_q <= 3'h6;
				vcd_pkg::SEL_YC_1_4: begin
					luma_q   <= 3'h1;
					chroma_q <= 3'h4;
				end
				vcd_pkg::SEL_YC_2_3: begin
					luma_q   <= 3'h2;
					chroma_q <= 3'h3;
				end
				vcd_pkg::SEL_YUV: begin
					luma_q   <= 3'h2;
					chroma_q <= 3'h3;
					v_q      <= 3'h6;
				end
				default: luma_q <= 3'h0;
			endcase
		end
	end

	logic       aux_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aux_q <= 1'b0;
		end else begin
			aux_q <= vcd_is_aux(st.sel);
		end
	end
	// ==========================================================
	// outputs
	assign adc_data_out        = st.adc_out;
	assign chroma_phase_marker = st.marker;
	assign luma_source         = luma_q;
	assign chroma_source       = chroma_q;
	assign v_source            = v_q;
	assign aux_enable          = aux_q;
	assign single_ended        = aux_q ? 6'h3C : 6'h00;
	assign leg_to_reference    = aux_q;
	assign aux_channel_sel     = st.auxch;
	assign dac0_data           = st.dac0;
	assign dac1_data           = st.dac1;
	assign dac2_data           = st.dac2;
	assign dac3_data           = st.dac3;
	assign dac_update          = st.upd;
	assign overlay_out         = st.osd;
	assign overlay_active      = st.osd_on;
	assign prdata              = st.rdata;
	assign pready              = st.ready;
	assign pslverr             = st.slverr;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_b_rise_mode(logic [1:0] m);
		b_rise && st.mode == m;
	endsequence

	a_adc_word_update: assert property (xtal_rise |=> adc_data_out == $past(settled[P_CORE + 2 +: DATA_W]))
		else $error("adc word not taken on crystal edge");
	a_adc_word_hold: assert property (!xtal_rise |=> $stable(adc_data_out))
		else $error("adc word changed without crystal edge");
	a_marker_cvbs: assert property (st.sel == vcd_pkg::SEL_CVBS_1 && xtal_rise |=> !chroma_phase_marker)
		else $error("marker high for composite");
	a_single_mark: assert property (s_b_rise_mode(vcd_pkg::MODE_SINGLE) ##0 settled[P_CKA]
		|=> dac_update == 4'h1 && dac0_data == $past(settled[P_DBUS +: DATA_W]))
		else $error("marked word missed DAC0");
	a_single_next: assert property (s_b_rise_mode(vcd_pkg::MODE_SINGLE) ##0 (!settled[P_CKA] && st.seen_mark)
		|=> st.steer == $past(st.steer) + 2'h1)
		else $error("steering did not advance");
	a_single_hold: assert property (s_b_rise_mode(vcd_pkg::MODE_SINGLE) ##0 !st.seen_mark |=> st.steer == 2'h0)
		else $error("steering left DAC0 before mark");
	a_dual_fall: assert property (st.mode == vcd_pkg::MODE_DUAL && a_fall && !b_rise && !a_rise && !b_fall
		|=> dac_update == 4'h4)
		else $error("dual mode falling edge not captured");
	a_mode3_cr: assert property (s_b_rise_mode(vcd_pkg::MODE_422) ##0 settled[P_CKA] |=> dac_update == 4'h4)
		else $error("Cr word not sent to DAC2");
	a_mode3_pair: assert property (s_b_rise_mode(vcd_pkg::MODE_422) ##0 (!settled[P_CKA] && st.chroma_turn)
		|=> dac_update == 4'h1 ##0 !st.chroma_turn)
		else $error("Cb word not sent to DAC0");
	a_mode_off: assert property (st.mode == vcd_pkg::MODE_OFF |=> dac_update == 4'h0)
		else $error("capture while off");
	a_overlay_gate: assert property (!overlay_active |-> overlay_out == 3'h0)
		else $error("overlay passed while disabled");
	a_apb_answer: assert property (apb_setup |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	a_aux_decode: assert property (st.sel == vcd_pkg::SEL_AUX_2 |=> aux_enable && luma_source == 3'h2)
		else $error("auxiliary decode wrong");
	a_yuv_decode: assert property (st.sel == vcd_pkg::SEL_YUV |=> luma_source == 3'h2 && v_source == 3'h6)
		else $error("component decode wrong");
endmodule
`default_nettype wire

// [vcd_pkg.sv]
/*
 constants for the video codec data ports: register map, field layout,
 select codes, capture modes and timing.
 assumes one system clock of 125 MHz and an APB master with 32-bit data.
*/
`default_nettype none
package vcd_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] REG_INPUT_SELECT = 8'h00;
	localparam logic [7:0] REG_DAC_MODE     = 8'h04;
	localparam logic [7:0] REG_AUX_CHANNEL  = 8'h08;
	localparam logic [7:0] REG_AUX_RESULT   = 8'h0C;
	localparam logic [7:0] REG_STATUS       = 8'h10;
	// ==========================================================
	// field widths and reset values
	localparam int          SEL_W       = 4;
	localparam int          MODE_W      = 2;
	localparam int          AUXCH_W     = 3;
	localparam int          AUXRES_W    = 8;
	localparam logic [3:0]  SEL_RESET   = 4'h0;
	localparam logic [1:0]  MODE_RESET  = 2'h1;
	localparam logic [2:0]  AUXCH_RESET = 3'h0;
	// ==========================================================
	// input select codes
	localparam logic [3:0] SEL_CVBS_1   = 4'h0;
	localparam logic [3:0] SEL_CVBS_2   = 4'h1;
	localparam logic [3:0] SEL_CVBS_3   = 4'h2;
	localparam logic [3:0] SEL_RESERVED = 4'h3;
	localparam logic [3:0] SEL_CVBS_5   = 4'h4;
	localparam logic [3:0] SEL_CVBS_6   = 4'h5;
	localparam logic [3:0] SEL_YC_1_4   = 4'h6;
	localparam logic [3:0] SEL_YC_2_3   = 4'h7;
	localparam logic [3:0] SEL_YUV      = 4'h8;
	localparam logic [3:0] SEL_AUX_1    = 4'h9;
	localparam logic [3:0] SEL_AUX_2    = 4'hA;
	// ==========================================================
	// capture modes
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_DUAL   = 2'h2;
	localparam logic [1:0] MODE_422    = 2'h3;
	// ==========================================================
	// data widths
	localparam int CORE_W = 12;
	localparam int HEAD_W = 2;
	localparam int DATA_W = 10;
	localparam int OSD_W  = 3;
	// ==========================================================
	// timing
	localparam int CLK_HZ          = 125000000;
	localparam int DAC_RATE_HZ     = 54000000;
	localparam int DAC0_RATE_HZ    = 200000000;
endpackage
`default_nettype wire

// [vcd_host_model.sv]
/*
 video processor model: drives the DAC capture pins and the overlay pins.
 assumes the block samples these pins on its own clock and needs each level
 held for at least two of its cycles on each side of a capture edge.
*/
`default_nettype none
module vcd_host_model (
	output var logic       dac_clock_a,
	output var logic       dac_clock_b,
	output var logic [9:0] dac_input_bus,
	output var logic [2:0] overlay_inputs,
	output var logic       overlay_switch_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// idle state: clocks stand still, bus held at 10'h2AA
	initial begin
		dac_clock_a = 1'b0;
		dac_clock_b = 1'b0;
		dac_input_bus = 10'h2AA;
		overlay_inputs = 3'h0;
		overlay_switch_enable = 1'b0;
	end
	// released bus shows the inverse of its last word
	task automatic idle();
		dac_clock_a = 1'b0;
		dac_input_bus = ~dac_input_bus;
	endtask
	// ==========================================================
	// one word latched on the rise of the b clock, a marks it
	task automatic send_marked(input logic [9:0] word, input logic mark);
		#2;
		dac_input_bus = word;
		dac_clock_a = mark;
		#60.5;
		dac_clock_b = 1'b1;
		#62.5;
		dac_clock_b = 1'b0;
	endtask
	// four words on a rise, b rise, a fall, b fall
	task automatic send_quad(input logic [3:0][9:0] w);
		#2;
		for (int i = 0; i < 4; i++) begin
			dac_input_bus = w[i];
			#15.625;
			if (i % 2 == 1) begin
				dac_clock_b = ~dac_clock_b;
			end else begin
				dac_clock_a = ~dac_clock_a;
			end
			#15.625;
		end
	endtask
	// overlay data and its enable level
	task automatic set_overlay(input logic [2:0] d, input logic en);
		#2;
		overlay_inputs = d;
		overlay_switch_enable = en;
	endtask
endmodule
`default_nettype wire

// [tb_top.sv]
/*
 testbench for the video codec data ports: registers, input select, digitizer
 output, DAC capture modes, overlay and reset.
 assumes vcd_pkg, vcd_data_ports and vcd_host_model are compiled first.
*/
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic        crystal_clock_in = 1'b0, aux_sar_done = 1'b0, rerr;
	logic [11:0] adc_core_sample = 12'h0;
	logic [7:0]  aux_sar_result = 8'h0;
	logic [31:0] prdata, rdata;
	logic        pready, pslverr, chroma_phase_marker, aux_enable, leg_to_reference, overlay_active;
	logic        dac_clock_a, dac_clock_b, overlay_switch_enable;
	logic [9:0]  adc_data_out, dac_input_bus, dac0_data, dac1_data, dac2_data, dac3_data;
	logic [2:0]  luma_source, chroma_source, v_source, aux_channel_sel, overlay_inputs, overlay_out;
	logic [5:0]  single_ended;
	logic [3:0]  dac_update;
	int          n_mismatch = 0;
	int          n_compared = 0;
	always #4 clk_sys = ~clk_sys;
	vcd_data_ports i_vcd_data_ports (
		.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.crystal_clock_in, .adc_core_sample, .adc_data_out, .chroma_phase_marker,
		.luma_source, .chroma_source, .v_source, .aux_enable, .single_ended, .leg_to_reference,
		.aux_channel_sel, .aux_sar_result, .aux_sar_done, .dac_clock_a, .dac_clock_b, .dac_input_bus,
		.dac0_data, .dac1_data, .dac2_data, .dac3_data, .dac_update,
		.overlay_inputs, .overlay_switch_enable, .overlay_out, .overlay_active
	);
	vcd_host_model i_vcd_host_model (
		.dac_clock_a, .dac_clock_b, .dac_input_bus, .overlay_inputs, .overlay_switch_enable
	);
	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rdata, e);
	endtask
	task automatic sar(input logic [7:0] v);
		aux_sar_result <= v;
		aux_sar_done <= 1'b1;
		@(posedge clk_sys);
		aux_sar_done <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic dacs(input logic [39:0] e);
		wait_clk(10);
		check(32'(dac0_data), 32'(e[9:0]));
		check(32'(dac1_data), 32'(e[19:10]));
		check(32'(dac2_data), 32'(e[29:20]));
		check(32'(dac3_data), 32'(e[39:30]));
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd_chk(vcd_pkg::REG_INPUT_SELECT, 32'(vcd_pkg::SEL_RESET));
		rd_chk(vcd_pkg::REG_DAC_MODE, 32'(vcd_pkg::MODE_RESET));
		rd_chk(vcd_pkg::REG_AUX_CHANNEL, 32'(vcd_pkg::AUXCH_RESET));
		wr(8'h14, 32'h3);
		check(32'(rerr), 32'h1);
		rd_chk(8'h14, 32'h0);
		wr(vcd_pkg::REG_DAC_MODE, 32'h2);
		rd_chk(vcd_pkg::REG_DAC_MODE, 32'h2);
		check(32'(rerr), 32'h0);
	endtask
	task automatic t_select();
		logic [8:0] src [11] = '{9'h040, 9'h080, 9'h0C0, 9'h000, 9'h140, 9'h180, 9'h060, 9'h098,
			9'h09E, 9'h040, 9'h080};
		for (int c = 0; c < 11; c++) begin
			wr(vcd_pkg::REG_INPUT_SELECT, 32'(c));
			wait_clk(3);
			check(32'({luma_source, chroma_source, v_source}), 32'(src[c]));
			check(32'({aux_enable, leg_to_reference, single_ended}), c > 8 ? 32'hFC : 32'h0);
			rd_chk(vcd_pkg::REG_INPUT_SELECT, 32'(c));
		end
	endtask
	task automatic t_aux();
		wr(vcd_pkg::REG_AUX_CHANNEL, 32'h5);
		wait_clk(2);
		check(32'(aux_channel_sel), 32'h5);
		wr(vcd_pkg::REG_INPUT_SELECT, 32'(vcd_pkg::SEL_AUX_1));
		sar(8'hA5);
		rd_chk(vcd_pkg::REG_STATUS, 32'h8);
		rd_chk(vcd_pkg::REG_AUX_RESULT, 32'hA5);
		wr(vcd_pkg::REG_INPUT_SELECT, 32'(vcd_pkg::SEL_CVBS_1));
		sar(8'h3C);
		rd_chk(vcd_pkg::REG_AUX_RESULT, 32'hA5);
	endtask
	task automatic t_adc();
		logic [3:0] codes [3] = '{vcd_pkg::SEL_YC_1_4, vcd_pkg::SEL_YUV, vcd_pkg::SEL_CVBS_1};
		logic [11:0] s;
		for (int c = 0; c < 3; c++) begin
			wr(vcd_pkg::REG_INPUT_SELECT, 32'(codes[c]));
			for (int k = 0; k < 6; k++) begin
				s = 12'hFFF - 12'(k) * 12'h135;
				adc_core_sample <= s;
				crystal_clock_in <= 1'b0;
				wait_clk(8);
				crystal_clock_in <= 1'b1;
				wait_clk(8);
				check(32'(adc_data_out), 32'(s[11:2]));
				check(32'(chroma_phase_marker), 32'(c == 0 ? k % 2 == 1 : c == 1 && k % 4 == 2));
			end
		end
		crystal_clock_in <= 1'b0;
	endtask
	task automatic t_mode1();
		wr(vcd_pkg::REG_DAC_MODE, 32'(vcd_pkg::MODE_SINGLE));
		i_vcd_host_model.send_marked(10'h111, 1'b0);
		i_vcd_host_model.send_marked(10'h122, 1'b0);
		i_vcd_host_model.idle();
		dacs({30'h0, 10'h122});
		rd_chk(vcd_pkg::REG_STATUS, 32'h0);
		for (int i = 0; i < 5; i++) i_vcd_host_model.send_marked(10'h200 + 10'(i), i == 0);
		i_vcd_host_model.idle();
		dacs({10'h203, 10'h202, 10'h201, 10'h204});
		rd_chk(vcd_pkg::REG_STATUS, 32'h4);
	endtask
	task automatic t_mode2();
		wr(vcd_pkg::REG_DAC_MODE, 32'(vcd_pkg::MODE_DUAL));
		i_vcd_host_model.send_quad({10'h303, 10'h302, 10'h301, 10'h300});
		i_vcd_host_model.idle();
		dacs({10'h303, 10'h302, 10'h301, 10'h300});
	endtask
	task automatic t_mode3();
		wr(vcd_pkg::REG_DAC_MODE, 32'(vcd_pkg::MODE_422));
		i_vcd_host_model.send_marked(10'h0C0, 1'b0);
		i_vcd_host_model.send_marked(10'h0A0, 1'b0);
		i_vcd_host_model.send_marked(10'h0E0, 1'b1);
		i_vcd_host_model.send_marked(10'h0A1, 1'b0);
		i_vcd_host_model.idle();
		dacs({10'h303, 10'h0E0, 10'h0A1, 10'h0C0});
		wr(vcd_pkg::REG_DAC_MODE, 32'(vcd_pkg::MODE_OFF));
		i_vcd_host_model.send_marked(10'h3FF, 1'b1);
		i_vcd_host_model.idle();
		dacs({10'h303, 10'h0E0, 10'h0A1, 10'h0C0});
	endtask
	task automatic t_overlay();
		i_vcd_host_model.set_overlay(3'h5, 1'b0);
		wait_clk(10);
		check(32'({overlay_active, overlay_out}), 32'h0);
		i_vcd_host_model.set_overlay(3'h5, 1'b1);
		wait_clk(10);
		check(32'({overlay_active, overlay_out}), 32'hD);
		i_vcd_host_model.set_overlay(3'h2, 1'b1);
		wait_clk(10);
		check(32'({overlay_active, overlay_out}), 32'hA);
	endtask
	task automatic t_mid_reset();
		rst_n <= 1'b0;
		wait_clk(5);
		check(32'(dac0_data), 32'h0);
		rst_n <= 1'b1;
		wait_clk(5);
		rd_chk(vcd_pkg::REG_DAC_MODE, 32'(vcd_pkg::MODE_RESET));
		rd_chk(vcd_pkg::REG_STATUS, 32'h0);
	endtask
	// ==========================================================
	// verdict and run order
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_clk(5);
		t_regs();
		t_select();
		t_aux();
		t_adc();
		t_mode1();
		t_mode2();
		t_mode3();
		t_overlay();
		t_mid_reset();
		finish_test();
	end
	initial begin
		#100us;
		n_mismatch++;
		finish_test();
	end
endmodule
`default_nettype wire
